// [hw/cid_pkg.sv]
// Purpose: Shared constants and types for the counter control-input decoder
// Assumes: CLK_SYS at 40 MHz, four BCD digits
// Notes:   Tri-level pins arrive as a two-bit code, see cid_tri_type
package cid_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int SCAN_T_NS = 100000;  // Digit on-time in ns
    localparam int SCAN_CYC = SCAN_T_NS * CLK_MHZ / 1000;
    localparam logic [11:0] SCAN_LAST = 12'(SCAN_CYC - 1);
    localparam logic [1:0] LAST_DIGIT = 2'h3;  // fourth_digit_strobe

    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_MASK = 4'h4;
    localparam logic [3:0] OFF_COUNT = 4'h8;
    localparam logic [3:0] OFF_COMPARE = 4'hC;
    localparam int EV_MATCH = 0;
    localparam int EV_ZERO = 1;
    localparam int EV_CARRY = 2;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [3:0] BCD_MAX = 4'h9;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CID_FLOAT = 2'b00,
        CID_LOW = 2'b01,
        CID_HIGH = 2'b10
    } cid_tri_type;

    // Segment order {g,f,e,d,c,b,a}; every digit lights a or b
    function automatic logic [6:0] cid_seg7(input logic [3:0] v);
        case (v)
            4'h0: return 7'h3F;
            4'h1: return 7'h06;
            4'h2: return 7'h5B;
            4'h3: return 7'h4F;
            4'h4: return 7'h66;
            4'h5: return 7'h6D;
            4'h6: return 7'h7D;
            4'h7: return 7'h07;
            4'h8: return 7'h7F;
            4'h9: return 7'h6F;
            default: return 7'h00;
        endcase
    endfunction
endpackage

// [hw/cid_scan_if.sv]
// Purpose: Link between the decoder core and the digit scanner
// Assumes: One clock domain
// Notes:   step is a one-cycle pulse at the end of each digit slot
interface cid_scan_if;
    logic stop;
    logic step;
    logic [1:0] digit;
    modport scanner (input stop, output step, output digit);
    modport user (output stop, input step, input digit);
endinterface

// [hw/cid_scan.sv]
// Purpose: Free-running multiplex scan, one digit slot per SCAN_CYC cycles
// Assumes: Stop is already synchronised
// Notes:   Stopping parks the scan on the fourth digit
module cid_scan (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Scan link
    cid_scan_if.scanner sif
);
    logic [11:0] div;
    logic [1:0] digit;

    // Slot divider, held at zero while stopped
    always_ff @(posedge clk) begin
        if (srst || sif.stop) begin
            div <= 12'h000;
        end else if (div == cid_pkg::SCAN_LAST) begin
            div <= 12'h000;
        end else begin
            div <= div + 12'h001;
        end
    end

    assign sif.step = !sif.stop && (div == cid_pkg::SCAN_LAST);

    // Digit pointer; wraps from the fourth digit to the first
    always_ff @(posedge clk) begin
        if (srst || sif.stop) begin
            digit <= cid_pkg::LAST_DIGIT;
        end else if (sif.step) begin
            digit <= digit + 2'h1;
        end
    end

    assign sif.digit = digit;

    property p_stop_park;
        @(posedge clk) disable iff (srst)
        sif.stop |=> (digit == cid_pkg::LAST_DIGIT) && (div == 12'h000);
    endproperty
    a_stop_park: assert property (p_stop_park) else $error("scan not parked");
endmodule // cid_scan

// [hw/cid_trilevel.sv]
// Purpose: Synchronise and decode the three tri-level control pins
// Assumes: Each pin arrives as {high,low} detector bits; 00 is floating
// Notes:   The impossible code 11 decodes as floating (normal operation)
module cid_trilevel (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw pin codes, three pairs
    input wire logic [5:0] raw,
    // Decoded states, three pairs of cid_tri_type codes
    output logic [5:0] state
);
    logic [5:0] s1;
    logic [5:0] s2;

    // Two-stage synchroniser; s1 feeds only s2
    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= 6'h00;
            s2 <= 6'h00;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end

    // Per pin decode into three distinct states
    for (genvar i = 0; i < 3; i++) begin : g_pin
        assign state[2*i +: 2] = (s2[2*i +: 2] == 2'b11) ?
            cid_pkg::CID_FLOAT : s2[2*i +: 2];
    end
endmodule // cid_trilevel

// [hw/cid_core.sv]
// Purpose: Four-digit up/down BCD counter with compare register, latches,
//          multiplexed display/BCD port and tri-level control decoding
// Assumes: Control and BCD pins asynchronous to CLK_SYS; count input already debounced
// Notes:   Registers reached over a plain strobe port, read data one cycle late
//
// Decided for this implementation: the placing of the registers and the strobed register port.
module cid_core (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Two-level control pins
    input wire logic COUNT_IN,
    input wire logic UP_DOWN,
    input wire logic STORE_N,
    input wire logic RESET_N,
    // Tri-level control pins, {high,low} detector pairs
    input wire logic [1:0] LOAD_CNT,
    input wire logic [1:0] LOAD_REG,
    input wire logic [1:0] DISP_CTL,
    // BCD port
    input wire logic [3:0] BCD_I,
    output logic [3:0] BCD_O,
    output logic BCD_OE_N,
    // Display
    output logic [3:0] DIGIT_STB,
    output logic [6:0] SEG,
    // Status pins
    output logic MATCH,
    output logic ZERO,
    output logic CARRY_BORROW,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ
);
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic count_prev;
    logic count_evt;
    logic [5:0] tri_st;
    cid_pkg::cid_tri_type lc_st;
    cid_pkg::cid_tri_type lr_st;
    cid_pkg::cid_tri_type dc_st;
    logic up;
    logic store_n_s;
    logic rst_n_s;
    logic load_cnt;
    logic load_reg;
    logic port_off;
    logic disp_off;
    logic [15:0] count;
    logic [15:0] cmp;
    logic [15:0] latch;
    logic [15:0] step_val;
    logic [4:0] chain;
    logic [4:0] lead;
    logic [3:0] cur_nib;
    logic cur_blank;
    logic do_count;
    logic match_prev;
    logic zero_prev;
    logic [2:0] events;
    logic [2:0] status;
    logic [2:0] mask;

    cid_scan_if sif ();

    // ----------------------------------------------------------------
    // Pin synchronisers and control decode
    // ----------------------------------------------------------------
    // Order {COUNT_IN, UP_DOWN, STORE_N, RESET_N, BCD_I}; control idle levels high
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pin_s1 <= 8'hF0;
            pin_s2 <= 8'hF0;
            count_prev <= 1'b1;
        end else begin
            pin_s1 <= {COUNT_IN, UP_DOWN, STORE_N, RESET_N, BCD_I};
            pin_s2 <= pin_s1;
            count_prev <= pin_s2[7];
        end
    end

    assign count_evt = pin_s2[7] && !count_prev;
    assign up = pin_s2[6];
    assign store_n_s = pin_s2[5];
    assign rst_n_s = pin_s2[4];

    cid_trilevel u_tri (
        .clk(CLK_SYS),
        .srst(SRST),
        .raw({DISP_CTL, LOAD_REG, LOAD_CNT}),
        .state(tri_st)
    );

    assign lc_st = cid_pkg::cid_tri_type'(tri_st[1:0]);
    assign lr_st = cid_pkg::cid_tri_type'(tri_st[3:2]);
    assign dc_st = cid_pkg::cid_tri_type'(tri_st[5:4]);
    assign load_cnt = (lc_st == cid_pkg::CID_HIGH);
    assign load_reg = (lr_st == cid_pkg::CID_HIGH);
    assign port_off = (lc_st == cid_pkg::CID_LOW) || (lr_st == cid_pkg::CID_LOW);
    assign disp_off = (lr_st == cid_pkg::CID_LOW);
    assign sif.stop = disp_off;

    cid_scan u_scan (
        .clk(CLK_SYS),
        .srst(SRST),
        .sif(sif)
    );

    // ----------------------------------------------------------------
    // Counter datapath
    // ----------------------------------------------------------------
    // Ripple of per-digit increment/decrement and leading-zero detect
    assign chain[0] = 1'b1;
    assign lead[4] = 1'b1;
    for (genvar i = 0; i < 4; i++) begin : g_digit
        logic [3:0] d;
        assign d = count[4*i +: 4];
        assign chain[i+1] = chain[i] && (up ? (d == cid_pkg::BCD_MAX) : (d == 4'h0));
        assign step_val[4*i +: 4] = !chain[i] ? d :
            up ? ((d == cid_pkg::BCD_MAX) ? 4'h0 : d + 4'h1) :
            ((d == 4'h0) ? cid_pkg::BCD_MAX : d - 4'h1);
        assign lead[i] = lead[i+1] && (latch[4*i +: 4] == 4'h0);
    end

    // Counting pauses while the counter is being loaded from the port
    assign do_count = count_evt && !load_cnt && rst_n_s;

    // Counter; keeps running with the display off
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            count <= cid_pkg::COUNT_RST;
        end else if (!rst_n_s) begin
            count <= cid_pkg::COUNT_RST;
        end else if (load_cnt && sif.step) begin
            count[4*sif.digit +: 4] <= pin_s2[3:0];
        end else if (do_count) begin
            count <= step_val;
        end
    end

    // Compare register; the reset pin does not touch it
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            cmp <= cid_pkg::COUNT_RST;
        end else if (load_reg && sif.step) begin
            cmp[4*sif.digit +: 4] <= pin_s2[3:0];
        end
    end

    // Carry/borrow pulse on wrap past 9999 or below 0000
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            CARRY_BORROW <= 1'b0;
        end else begin
            CARRY_BORROW <= do_count && chain[4];
        end
    end

    // Output latches follow the counter while store is low
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            latch <= cid_pkg::COUNT_RST;
        end else if (!store_n_s) begin
            latch <= count;
        end
    end

    // Compare outputs are plain gates, so they glitch while a load crosses codes
    assign MATCH = (count == cmp);
    assign ZERO = (count == cid_pkg::COUNT_RST);

    // ----------------------------------------------------------------
    // Display and BCD port
    // ----------------------------------------------------------------
    assign cur_nib = latch[4*sif.digit +: 4];
    assign cur_blank = lead[sif.digit] && (sif.digit != 2'h0) &&
        (dc_st != cid_pkg::CID_LOW);

    // Registered drivers; strobes lag the scan pointer by one cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            SEG <= 7'h00;
            DIGIT_STB <= 4'h0;
            BCD_O <= 4'h0;
            BCD_OE_N <= 1'b1;
        end else begin
            if (disp_off || dc_st == cid_pkg::CID_HIGH || cur_blank) begin
                SEG <= 7'h00;
            end else begin
                SEG <= cid_pkg::cid_seg7(cur_nib);
            end
            DIGIT_STB <= disp_off ? 4'h0 : (4'h1 << sif.digit);
            BCD_O <= cur_nib;
            // Port turns round to input while either load samples it
            BCD_OE_N <= port_off || load_cnt || load_reg;
        end
    end

    // ----------------------------------------------------------------
    // Events, status and register port
    // ----------------------------------------------------------------
    // Start high: count and register both clear, so no false edge after reset
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            match_prev <= 1'b1;
            zero_prev <= 1'b1;
        end else begin
            match_prev <= MATCH;
            zero_prev <= ZERO;
        end
    end

    assign events[cid_pkg::EV_MATCH] = MATCH && !match_prev;
    assign events[cid_pkg::EV_ZERO] = ZERO && !zero_prev;
    assign events[cid_pkg::EV_CARRY] = CARRY_BORROW;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            status <= cid_pkg::STATUS_RST;
        end else if (WR && ADDR == cid_pkg::OFF_STATUS) begin
            status <= (status & ~WDATA[2:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mask <= cid_pkg::MASK_RST;
        end else if (WR && ADDR == cid_pkg::OFF_MASK) begin
            mask <= WDATA[2:0];
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_SYS) begin
        if (SRST || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                cid_pkg::OFF_STATUS: RDATA <= {29'h0, status};
                cid_pkg::OFF_MASK: RDATA <= {29'h0, mask};
                cid_pkg::OFF_COUNT: RDATA <= {16'h0000, count};
                cid_pkg::OFF_COMPARE: RDATA <= {16'h0000, cmp};
                default: RDATA <= 32'h0000_0000;
            endcase
        end
    end

    assign IRQ = |(status & mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    property p_store;
        !store_n_s |=> latch == $past(count);
    endproperty
    a_store: assert property (p_store) else $error("latch missed count");

    property p_up_step;
        do_count && up && count[3:0] != cid_pkg::BCD_MAX |=>
            count[3:0] == $past(count[3:0]) + 4'h1;
    endproperty
    a_up_step: assert property (p_up_step) else $error("up count wrong");

    property p_down_step;
        do_count && !up && count[3:0] != 4'h0 |=>
            count[3:0] == $past(count[3:0]) - 4'h1;
    endproperty
    a_down_step: assert property (p_down_step) else $error("down count wrong");

    property p_clear;
        !rst_n_s |=> count == 16'h0000 && cmp == $past(cmp);
    endproperty
    a_clear: assert property (p_clear) else $error("reset pin misbehaved");

    property p_port_off;
        port_off |=> BCD_OE_N;
    endproperty
    a_port_off: assert property (p_port_off) else $error("port driven while off");

    property p_disp_off;
        disp_off ##1 disp_off |=> DIGIT_STB == 4'h0 && SEG == 7'h00 && sif.digit == 2'h3;
    endproperty
    a_disp_off: assert property (p_disp_off) else $error("display not off");

    property p_seg_off;
        dc_st == cid_pkg::CID_HIGH |=> SEG == 7'h00;
    endproperty
    a_seg_off: assert property (p_seg_off) else $error("segments lit");

    property p_seg_ab;
        SEG != 7'h00 |-> SEG[0] || SEG[1];
    endproperty
    a_seg_ab: assert property (p_seg_ab) else $error("digit without a or b");

    property p_load_reg;
        load_reg && sif.step |=> cmp[4*$past(sif.digit) +: 4] == $past(pin_s2[3:0]);
    endproperty
    a_load_reg: assert property (p_load_reg) else $error("register digit not loaded");

    property p_dual_load;
        load_cnt && load_reg && sif.step |=>
            count[4*$past(sif.digit) +: 4] == cmp[4*$past(sif.digit) +: 4];
    endproperty
    a_dual_load: assert property (p_dual_load) else $error("dual load differs");

    c_carry: cover property (CARRY_BORROW);
    c_match: cover property (events[cid_pkg::EV_MATCH]);
    c_load_scan: cover property (load_cnt && sif.step && sif.digit == 2'h3);
    c_irq: cover property (IRQ);
endmodule // cid_core

// [bench/cid_switch_model.sv]
// Purpose: Thumbwheel switch bank on the multiplexed BCD port
// Assumes: Switches are true BCD, diode isolated, open switches read 0000
// Notes:   Device drive overrides the switches through the isolation resistors
module cid_switch_model (
    // Scan and device drive
    input wire logic [3:0] digit_stb,
    input wire logic oe_n,
    input wire logic [3:0] drv,
    // Value set on the switches, digit 0 least significant
    input wire logic [15:0] preset,
    // Wire level seen at the port
    output logic [3:0] bcd
);
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------------------------------
    // Port wire level
    // -----------------------------------------------------------------
    // One switch bank feeds both loads, so both see the same value
    always_comb begin
        if (!oe_n) begin
            bcd = drv;
        end else begin
            case (digit_stb) // Only the strobed digit's switch reaches the port
                4'b0001: bcd = preset[3:0];
                4'b0010: bcd = preset[7:4];
                4'b0100: bcd = preset[11:8];
                4'b1000: bcd = preset[15:12];
                default: bcd = 4'h0; // No strobe: all diodes off, pull-down wins
            endcase
        end
    end
endmodule // cid_switch_model

// [bench/counter_control_input_decoder_bench.sv]
// Purpose: Self-checking bench for the control-input decoder core
// Assumes: Tri-level pins driven as {high,low} codes from cid_pkg
// Notes:   Full scans take 16000 cycles, so display checks are kept few
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module counter_control_input_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic count_in = 1'b0, up_down = 1'b1, store_n = 1'b1, reset_n = 1'b1;
    logic [1:0] load_cnt = 2'b00, load_reg = 2'b00, disp_ctl = 2'b00;
    logic [3:0] bcd_i, bcd_o, digit_stb, addr = 4'h0;
    logic [6:0] seg;
    logic [31:0] wdata = 32'h0, rdata;
    logic wr = 1'b0, rd = 1'b0, bcd_oe_n, match, zero, carry_borrow, irq;
    logic [15:0] preset = 16'h1234;
    logic carry_seen = 1'b0;
    int errors = 0;
    int total_checks = 0;

    // Clock, 25 ns period
    always #12.5 clk_sys = ~clk_sys;

    // Catch the one-cycle wrap pulse wherever it lands
    always @(posedge clk_sys) if (carry_borrow === 1'b1) carry_seen = 1'b1;

    cid_core u_dut (.CLK_SYS(clk_sys), .SRST(srst), .COUNT_IN(count_in), .UP_DOWN(up_down),
        .STORE_N(store_n), .RESET_N(reset_n), .LOAD_CNT(load_cnt), .LOAD_REG(load_reg),
        .DISP_CTL(disp_ctl), .BCD_I(bcd_i), .BCD_O(bcd_o), .BCD_OE_N(bcd_oe_n),
        .DIGIT_STB(digit_stb), .SEG(seg), .MATCH(match), .ZERO(zero),
        .CARRY_BORROW(carry_borrow), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq));
    cid_switch_model u_sw (.digit_stb(digit_stb), .oe_n(bcd_oe_n), .drv(bcd_o),
        .preset(preset), .bcd(bcd_i));

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic report_and_stop;
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask
    // Count pulses held three cycles high and low, past the synchroniser
    task automatic pulse_count(input logic dir, input int n);
        @(posedge clk_sys);
        up_down <= dir;
        cyc(4);
        repeat (n) begin
            count_in <= 1'b1;
            cyc(3);
            count_in <= 1'b0;
            cyc(3);
        end
        cyc(6);
    endtask
    // Bounded wait for a given strobe, then settle into the slot
    task automatic wait_stb(input logic [3:0] m);
        int k = 0;
        while (digit_stb !== m && k < 5 * cid_pkg::SCAN_CYC) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 5 * cid_pkg::SCAN_CYC) errors++;
        cyc(2);
        #1;
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset_state;
        chk_reg(cid_pkg::OFF_COUNT, 32'h0);
        chk_reg(cid_pkg::OFF_MASK, 32'h0);
        chk_reg(4'h2, 32'h0); // Unmapped reads as zero
        chk_reg(cid_pkg::OFF_STATUS, 32'h0);
        `CHK({zero, match, bcd_oe_n, irq}, 4'hC)
    endtask
    // Both loads raised on the same edge, held one full scan
    task automatic t_load_both;
        @(posedge clk_sys);
        load_cnt <= cid_pkg::CID_HIGH;
        load_reg <= cid_pkg::CID_HIGH;
        cyc(8);
        `CHK(bcd_oe_n, 1'b1)
        cyc(4 * cid_pkg::SCAN_CYC + 20);
        load_cnt <= cid_pkg::CID_FLOAT;
        load_reg <= cid_pkg::CID_FLOAT;
        cyc(10);
        chk_reg(cid_pkg::OFF_COUNT, 32'h1234);
        chk_reg(cid_pkg::OFF_COMPARE, 32'h1234);
        `CHK(match, 1'b1)
    endtask
    task automatic t_count_match_reset;
        wr_reg(cid_pkg::OFF_STATUS, 32'h7);
        pulse_count(1'b0, 1);
        chk_reg(cid_pkg::OFF_COUNT, 32'h1233);
        `CHK(match, 1'b0)
        pulse_count(1'b1, 1);
        `CHK(match, 1'b1)
        chk_reg(cid_pkg::OFF_STATUS, 32'h1);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        cyc(6);
        reset_n <= 1'b1;
        cyc(6);
        chk_reg(cid_pkg::OFF_COUNT, 32'h0);
        chk_reg(cid_pkg::OFF_COMPARE, 32'h1234);
        `CHK(zero, 1'b1)
        chk_reg(cid_pkg::OFF_STATUS, 32'h3);
    endtask
    // Borrow from 0000 raises, masks and clears the interrupt
    task automatic t_wrap_irq;
        wr_reg(cid_pkg::OFF_STATUS, 32'h7);
        wr_reg(cid_pkg::OFF_MASK, 32'h4);
        carry_seen = 1'b0;
        pulse_count(1'b0, 1);
        chk_reg(cid_pkg::OFF_COUNT, 32'h9999);
        `CHK({carry_seen, irq, zero}, 3'h6)
        wr_reg(cid_pkg::OFF_MASK, 32'h0);
        #1 `CHK(irq, 1'b0)
        wr_reg(cid_pkg::OFF_MASK, 32'h4);
        #1 `CHK(irq, 1'b1)
        wr_reg(cid_pkg::OFF_STATUS, 32'h4);
        #1 `CHK(irq, 1'b0)
    endtask
    // Latch 9999, count on; port and segments keep the latched value
    task automatic t_store;
        @(posedge clk_sys);
        store_n <= 1'b0;
        cyc(6);
        store_n <= 1'b1;
        cyc(6);
        pulse_count(1'b1, 1);
        wait_stb(4'b0001);
        `CHK({bcd_oe_n, bcd_o}, 5'h09)
        `CHK(seg, 7'h6F)
        `CHK(|seg[1:0], 1'b1)
    endtask
    task automatic t_disp_ctl;
        pulse_count(1'b1, 1);
        @(posedge clk_sys);
        store_n <= 1'b0;
        disp_ctl <= cid_pkg::CID_LOW;
        cyc(6);
        store_n <= 1'b1;
        wait_stb(4'b1000);
        `CHK(seg, 7'h3F)
        @(posedge clk_sys);
        disp_ctl <= cid_pkg::CID_FLOAT;
        wait_stb(4'b0100);
        `CHK(seg, 7'h00)
        @(posedge clk_sys);
        disp_ctl <= cid_pkg::CID_HIGH;
        wait_stb(4'b0001);
        `CHK(seg, 7'h00)
        @(posedge clk_sys);
        disp_ctl <= cid_pkg::CID_FLOAT;
    endtask
    // Display off keeps counting; release restarts the scan at digit 4
    task automatic t_display_off;
        @(posedge clk_sys);
        load_reg <= cid_pkg::CID_LOW;
        cyc(8);
        `CHK({digit_stb, seg, bcd_oe_n}, 12'h001)
        pulse_count(1'b1, 1);
        chk_reg(cid_pkg::OFF_COUNT, 32'h0002);
        @(posedge clk_sys);
        load_reg <= cid_pkg::CID_FLOAT;
        cyc(5);
        `CHK(digit_stb, 4'b1000)
        load_cnt <= cid_pkg::CID_LOW;
        cyc(8);
        `CHK(bcd_oe_n, 1'b1)
        chk_reg(cid_pkg::OFF_COUNT, 32'h0002);
        chk_reg(cid_pkg::OFF_COMPARE, 32'h1234);
    endtask

    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        cyc(3);
        srst <= 1'b0;
        t_reset_state();
        t_load_both();
        t_count_match_reset();
        t_wrap_irq();
        t_store();
        t_disp_ctl();
        t_display_off();
        report_and_stop();
    end
    // Whole run is a little over three scans; five is a hang
    initial begin
        cyc(5 * 4 * cid_pkg::SCAN_CYC);
        errors++;
        report_and_stop();
    end
endmodule // counter_control_input_decoder_bench
